//--- cad_decoder.sv
// Addressing mode decoder: takes prefix, opcode and operand bytes, reads pointers, forms the address.
`include "cad_defines.svh"
//
// Behaviour
// RULE_01: Immediate instructions are opcode plus one byte holding the operand value.
// RULE_02: Short direct takes one address byte, reaching 00 to FF.
// RULE_03: Long direct takes a two-byte address word, reaching all 64 Kbytes.
// RULE_04: Indexed address is the unsigned sum of X or Y and the offset.
// RULE_05: Indexed without offset takes no byte and uses the index alone.
// RULE_06: Short indexed takes a one-byte offset, reaching 00 to 1FE.
// RULE_07: Long indexed takes a two-byte offset word plus index, full 64 Kbytes.
// RULE_08: Indirect modes read the operand address from memory at the pointer byte.
// RULE_09: Short indirect reads a one-byte pointer, confining addresses to 00 to FF.
// RULE_10: Long indirect forms read a two-byte pointer via one pointer-address byte.
// RULE_11: Indirect-indexed address is index plus the pointer read from memory.
// RULE_12: Short indirect-indexed adds index to a byte pointer, reaching 00 to 1FE.
// RULE_13: Load, compare, bit compare, logical and add/subtract accept long and short forms.
// RULE_14: Memory-to-memory, bit, shift, call and jump instructions accept short forms only.
// RULE_15: Relative modes add an 8-bit signed offset to the program counter.
// RULE_16: Direct relative takes the offset byte straight after the opcode.
// RULE_17: Indirect relative reads the offset from memory at the following byte.
// RULE_18: Sixty-three instructions are recognised, grouped into thirteen classes.
// RULE_19: Inherent instructions are a single opcode byte with no operand bytes.
// RULE_20: Prefix 90 makes an X-based immediate, direct, indexed or inherent instruction use Y.
// RULE_21: Prefix 92 turns direct forms and X-indexed into their indirect forms.
// RULE_22: Prefix 91 turns X indirect-indexed into Y indirect-indexed.
// RULE_23: Index registers are unsigned bytes; relative offsets are sign-extended first.
// RULE_24: Two-byte words take the first fetched byte as the high byte.
module cad_decoder (
    // Clock and reset
    input  wire logic               SYS_CLK_I,
    input  wire logic               NRST_I,
    // Instruction byte stream
    input  wire logic               BYTE_VALID_I,
    input  wire logic [7:0]         BYTE_I,
    input  wire cad_pkg::cad_predec_s PREDEC_I,
    output logic                    BYTE_READY_O,
    // Core state
    input  wire logic [7:0]         IDX_X_I,
    input  wire logic [7:0]         IDX_Y_I,
    input  wire logic [15:0]        PC_I,
    // Data memory read port
    output logic                    MEM_REQ_O,
    output logic [15:0]             MEM_ADDR_O,
    input  wire logic               MEM_ACK_I,
    input  wire logic [7:0]         MEM_RDATA_I,
    // Decoded result
    output logic                    DONE_O,
    output cad_pkg::cad_result_s    RESULT_O
);
    import cad_pkg::*;

    logic            rst_meta_ff;
    logic            rst_n;
    cad_state_e      state_ff;
    cad_pfx_e        pfx_ff;
    cad_mode_e       mode_ff;
    logic            use_y_ff;
    logic            bad_ff;
    logic [5:0]      insn_ff;
    logic [1:0]      need_ff;
    logic [1:0]      cnt_ff;
    logic [1:0][7:0] opnd_ff;
    logic [1:0][7:0] ptr_ff;
    logic [1:0]      rd_idx_ff;
    logic            byte_ready_ff;
    logic            mem_req_ff;
    logic [15:0]     mem_addr_ff;
    logic            done_ff;
    cad_result_s     result_ff;

    cad_pfx_e        byte_pfx;
    cad_mode_e       map_mode;
    logic            map_use_y;
    logic            map_bad;
    logic            take;
    logic            take_opcode;
    logic            last_opnd;
    logic [15:0]     ea;
    logic [15:0]     target;
    logic [7:0]      operand;

    // Reset is released through two stages so that every flop leaves reset on the same edge.
    always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            rst_meta_ff <= 1'b0;
            rst_n       <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_n       <= rst_meta_ff;
        end
    end

    always_comb begin
        unique case (BYTE_I)
            `CAD_PFX_Y_SUBST:    byte_pfx = PFX_Y_SUBST;
            `CAD_PFX_INDIRECT:   byte_pfx = PFX_INDIRECT;
            `CAD_PFX_Y_INDIRECT: byte_pfx = PFX_Y_INDIRECT;
            default:             byte_pfx = PFX_NONE;
        endcase
    end

    assign take        = BYTE_VALID_I && byte_ready_ff;
    // A prefix is only recognised as the first byte; after one, the next byte is the opcode.
    assign take_opcode = take && (state_ff == ST_IDLE) && !(byte_pfx != PFX_NONE && pfx_ff == PFX_NONE);
    assign last_opnd   = take && (state_ff == ST_OPND) && (cnt_ff == need_ff - 2'h1);

    cad_prefix_map u_prefix_map (
        .pfx_i   (pfx_ff),
        .base_i  (PREDEC_I.mode),
        .mode_o  (map_mode),
        .use_y_o (map_use_y),
        .bad_o   (map_bad)
    );

    cad_ea_calc u_ea_calc (
        .mode_i    (mode_ff),
        .use_y_i   (use_y_ff),
        .opnd_i    (opnd_ff),
        .ptr_i     (ptr_ff),
        .idx_x_i   (IDX_X_I),
        .idx_y_i   (IDX_Y_I),
        .pc_i      (PC_I),
        .ea_o      (ea),
        .target_o  (target),
        .operand_o (operand)
    );

    // Sequencing of one instruction.
    always_ff @(posedge SYS_CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= ST_IDLE;
        end else begin
            unique case (state_ff)
                ST_IDLE: begin
                    if (take_opcode) begin
                        state_ff <= (opnd_bytes(map_mode) == 2'h0) ? ST_FIN : ST_OPND; // RULE_19 RULE_05
                    end
                end
                ST_OPND: begin
                    if (last_opnd) begin
                        state_ff <= (ptr_reads(mode_ff) == 2'h0) ? ST_FIN : ST_READ; // RULE_08
                    end
                end
                ST_READ: begin
                    if (MEM_ACK_I && rd_idx_ff == ptr_reads(mode_ff) - 2'h1) begin
                        state_ff <= ST_FIN;
                    end
                end
                ST_FIN: begin
                    state_ff <= ST_IDLE;
                end
            endcase
        end
    end

    // Prefix capture.
    always_ff @(posedge SYS_CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            pfx_ff <= PFX_NONE;
        end else if (take && state_ff == ST_IDLE) begin
            pfx_ff <= take_opcode ? PFX_NONE : byte_pfx; // RULE_20 RULE_21 RULE_22
        end
    end

    // Opcode capture: final mode, index choice and legality.
    always_ff @(posedge SYS_CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            mode_ff  <= MODE_INH;
            use_y_ff <= 1'b0;
            bad_ff   <= 1'b0;
            insn_ff  <= 6'h00;
            need_ff  <= 2'h0;
        end else if (take_opcode) begin
            mode_ff  <= map_mode;
            use_y_ff <= map_use_y;
            insn_ff  <= PREDEC_I.insn;
            need_ff  <= opnd_bytes(map_mode); // RULE_01 RULE_02 RULE_03 RULE_06 RULE_07
            // Long forms are refused for short-only instructions; ids past the last one are refused in any form.
            bad_ff   <= map_bad || (PREDEC_I.insn >= `CAD_INSN_COUNT) // RULE_18
                        || (is_long(map_mode) && !long_ok(PREDEC_I.insn)); // RULE_13 RULE_14
        end
    end

    // Operand bytes, stored in fetch order so the first byte becomes the high byte.
    always_ff @(posedge SYS_CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            cnt_ff  <= 2'h0;
            opnd_ff <= '0;
        end else if (take_opcode) begin
            cnt_ff  <= 2'h0;
            opnd_ff <= '0;
        end else if (take && state_ff == ST_OPND) begin
            opnd_ff[cnt_ff[0]] <= BYTE_I; // RULE_24
            cnt_ff             <= cnt_ff + 2'h1;
        end
    end

    // Pointer reads from data memory; the request holds until acknowledged.
    always_ff @(posedge SYS_CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            mem_req_ff  <= 1'b0;
            mem_addr_ff <= `CAD_WORD_RST;
            rd_idx_ff   <= 2'h0;
            ptr_ff      <= '0;
        end else if (last_opnd && ptr_reads(mode_ff) != 2'h0) begin
            mem_req_ff  <= 1'b1;
            // The pointer address is always the first operand byte, in page zero.
            mem_addr_ff <= {`CAD_PAGE_ZERO, (cnt_ff == 2'h0) ? BYTE_I : opnd_ff[0]}; // RULE_08 RULE_10
            rd_idx_ff   <= 2'h0;
            ptr_ff      <= '0;
        end else if (state_ff == ST_READ && MEM_ACK_I) begin
            ptr_ff[rd_idx_ff[0]] <= MEM_RDATA_I; // RULE_09 RULE_10 RULE_17 RULE_24
            if (rd_idx_ff == ptr_reads(mode_ff) - 2'h1) begin
                mem_req_ff <= 1'b0;
            end else begin
                mem_addr_ff <= mem_addr_ff + 16'h0001;
                rd_idx_ff   <= rd_idx_ff + 2'h1;
            end
        end
    end

    // Byte stream back-pressure: bytes are only taken while a prefix, opcode or operand is due.
    always_ff @(posedge SYS_CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            byte_ready_ff <= 1'b0;
        end else if (take_opcode) begin
            byte_ready_ff <= opnd_bytes(map_mode) != 2'h0;
        end else if (last_opnd || state_ff == ST_READ) begin
            byte_ready_ff <= 1'b0;
        end else begin
            byte_ready_ff <= (state_ff == ST_FIN) || (state_ff == ST_IDLE) || (state_ff == ST_OPND);
        end
    end

    // Result, registered on the cycle after the last byte or pointer arrived.
    always_ff @(posedge SYS_CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            done_ff   <= 1'b0;
            result_ff <= '0;
        end else begin
            done_ff <= state_ff == ST_FIN;
            if (state_ff == ST_FIN) begin
                result_ff.ea      <= ea; // RULE_04 RULE_11
                result_ff.target  <= target; // RULE_15
                result_ff.operand <= operand;
                result_ff.mode    <= mode_ff;
                result_ff.cls     <= insn_class(insn_ff); // RULE_18
                result_ff.insn    <= insn_ff;
                result_ff.use_y   <= use_y_ff;
                result_ff.len     <= need_ff;
                result_ff.illegal <= bad_ff;
            end
        end
    end

    assign BYTE_READY_O = byte_ready_ff;
    assign MEM_REQ_O    = mem_req_ff;
    assign MEM_ADDR_O   = mem_addr_ff;
    assign DONE_O       = done_ff;
    assign RESULT_O     = result_ff;

    property p_imm_len;
        @(posedge SYS_CLK_I) disable iff (!rst_n)
        (done_ff && result_ff.mode == MODE_IMM) |-> (result_ff.len == 2'h1 && result_ff.operand == opnd_ff[0]);
    endproperty
    a_imm_len: assert property (p_imm_len) else $error("Immediate is not one operand byte."); // RULE_01

    property p_dir_short;
        @(posedge SYS_CLK_I) disable iff (!rst_n)
        (done_ff && result_ff.mode == MODE_DIR_S) |-> (result_ff.ea == {8'h00, opnd_ff[0]} && result_ff.len == 2'h1);
    endproperty
    a_dir_short: assert property (p_dir_short) else $error("Short direct address wrong."); // RULE_02

    property p_dir_long;
        @(posedge SYS_CLK_I) disable iff (!rst_n)
        (done_ff && result_ff.mode == MODE_DIR_L)
            |-> (result_ff.ea == {opnd_ff[0], opnd_ff[1]} && result_ff.len == 2'h2);
    endproperty
    a_dir_long: assert property (p_dir_long) else $error("Long direct address wrong."); // RULE_03

    property p_idx_short_range;
        @(posedge SYS_CLK_I) disable iff (!rst_n)
        (done_ff && result_ff.mode inside {MODE_IDX_S, MODE_IIX_S}) |-> result_ff.ea <= `CAD_SHORT_IDX_MAX;
    endproperty
    a_idx_short_range: assert property (p_idx_short_range) else $error("Short indexed address past 1FE."); // RULE_06

    property p_no_opnd_timing;
        @(posedge SYS_CLK_I) disable iff (!rst_n)
        (take_opcode && opnd_bytes(map_mode) == 2'h0) |-> ##2 (done_ff && result_ff.len == 2'h0);
    endproperty
    a_no_opnd_timing: assert property (p_no_opnd_timing) else $error("Zero-operand instruction late."); // RULE_19

    property p_ptr_addr;
        @(posedge SYS_CLK_I) disable iff (!rst_n)
        $rose(mem_req_ff) |-> (mem_addr_ff == {8'h00, opnd_ff[0]} && ptr_reads(mode_ff) != 2'h0);
    endproperty
    a_ptr_addr: assert property (p_ptr_addr) else $error("Pointer read not at first operand byte."); // RULE_08

    property p_ind_short_page;
        @(posedge SYS_CLK_I) disable iff (!rst_n)
        (done_ff && result_ff.mode == MODE_IND_S) |-> result_ff.ea == {8'h00, ptr_ff[0]};
    endproperty
    a_ind_short_page: assert property (p_ind_short_page) else $error("Short indirect left page zero."); // RULE_09

    property p_long_refused;
        @(posedge SYS_CLK_I) disable iff (!rst_n)
        (done_ff && is_long(result_ff.mode) && !long_ok(result_ff.insn)) |-> result_ff.illegal;
    endproperty
    a_long_refused: assert property (p_long_refused) else $error("Long form accepted for short-only op."); // RULE_14

    property p_rel_direct;
        @(posedge SYS_CLK_I) disable iff (!rst_n)
        (state_ff == ST_FIN && mode_ff == MODE_REL_D)
            |=> result_ff.target == $past(PC_I) + {{8{opnd_ff[0][7]}}, opnd_ff[0]};
    endproperty
    a_rel_direct: assert property (p_rel_direct) else $error("Relative target wrong."); // RULE_16

    // A pointer read holds its request and keeps the byte stream shut until the ack.
    property p_ptr_hold;
        @(posedge SYS_CLK_I) disable iff (!rst_n)
        (mem_req_ff && !MEM_ACK_I)
            |=> (mem_req_ff && $stable(mem_addr_ff));
    endproperty
    a_ptr_hold: assert property (p_ptr_hold) else $error("Pointer read dropped early."); // RULE_08

    property p_ptr_no_byte;
        @(posedge SYS_CLK_I) disable iff (!rst_n)
        mem_req_ff
            |-> !byte_ready_ff;
    endproperty
    a_ptr_no_byte: assert property (p_ptr_no_byte) else $error("Bytes taken during pointer read."); // RULE_08

    // Without an offset byte the address can only be the index itself.
    property p_idx_none;
        @(posedge SYS_CLK_I) disable iff (!rst_n)
        (done_ff && result_ff.mode == MODE_IDX_0)
            |-> result_ff.ea[15:8] == 8'h00;
    endproperty
    a_idx_none: assert property (p_idx_none) else $error("No-offset index left page zero."); // RULE_05
endmodule // cad_decoder

//--- cad_defines.svh
// Constants of the addressing mode decoder: prefix values, instruction ids and reset values.
`ifndef CAD_DEFINES_SVH
`define CAD_DEFINES_SVH

// Prefix byte values.
`define CAD_PFX_Y_SUBST       8'h90
`define CAD_PFX_Y_INDIRECT    8'h91
`define CAD_PFX_INDIRECT      8'h92

// Number of recognised instructions.
`define CAD_INSN_COUNT        6'h3f

// First instruction id of each functional class after the load class; ids run contiguously up to 62.
`define CAD_ID_STACK          6'h02
`define CAD_ID_INCDEC         6'h05
`define CAD_ID_COMPARE        6'h07
`define CAD_ID_LOGICAL        6'h0a
`define CAD_ID_BITOP          6'h0f
`define CAD_ID_BITJMP         6'h11
`define CAD_ID_ARITH          6'h13
`define CAD_ID_SHIFT          6'h18
`define CAD_ID_UNCOND         6'h1f
`define CAD_ID_COND           6'h27
`define CAD_ID_INTR           6'h37
`define CAD_ID_CCFLAG         6'h3b

// Instructions allowed in long addressing forms, one bit per instruction id.
`define CAD_LONG_OK_MASK      64'h0000_0000_0078_1e81

// Reset values, page zero high byte and short indexed limit.
`define CAD_BYTE_RST          8'h00
`define CAD_WORD_RST          16'h0000
`define CAD_PAGE_ZERO         8'h00
`define CAD_SHORT_IDX_MAX     16'h01fe

`endif

//--- cad_pkg.sv
// Types and mode property functions of the addressing mode decoder.
package cad_pkg;
`include "cad_defines.svh"

    typedef enum logic [4:0] {
        MODE_INH, MODE_IMM, MODE_DIR_S, MODE_DIR_L, MODE_IDX_0, MODE_IDX_S, MODE_IDX_L,
        MODE_IND_S, MODE_IND_L, MODE_IIX_S, MODE_IIX_L, MODE_REL_D, MODE_REL_I,
        MODE_BIT_D, MODE_BIT_I, MODE_BTJ_D, MODE_BTJ_I
    } cad_mode_e;

    typedef enum logic [3:0] {
        CLS_LOAD, CLS_STACK, CLS_INCDEC, CLS_COMPARE, CLS_LOGICAL, CLS_BITOP, CLS_BITJMP,
        CLS_ARITH, CLS_SHIFT, CLS_UNCOND, CLS_COND, CLS_INTR, CLS_CCFLAG
    } cad_class_e;

    typedef enum logic [1:0] {PFX_NONE, PFX_Y_SUBST, PFX_INDIRECT, PFX_Y_INDIRECT} cad_pfx_e;

    typedef enum logic [2:0] {ST_IDLE, ST_OPND, ST_READ, ST_FIN} cad_state_e;

    typedef struct packed {
        logic [5:0] insn;
        cad_mode_e  mode;
    } cad_predec_s;

    typedef struct packed {
        logic [15:0] ea;
        logic [15:0] target;
        logic [7:0]  operand;
        cad_mode_e   mode;
        cad_class_e  cls;
        logic [5:0]  insn;
        logic        use_y;
        logic [1:0]  len;
        logic        illegal;
    } cad_result_s;

    function automatic logic [1:0] opnd_bytes(input cad_mode_e m);
        unique case (m)
            MODE_INH, MODE_IDX_0:                 opnd_bytes = 2'h0;
            MODE_DIR_L, MODE_IDX_L, MODE_BTJ_D,
            MODE_BTJ_I:                           opnd_bytes = 2'h2;
            default:                              opnd_bytes = 2'h1;
        endcase
    endfunction

    function automatic logic [1:0] ptr_reads(input cad_mode_e m);
        unique case (m)
            MODE_IND_L, MODE_IIX_L:                               ptr_reads = 2'h2;
            MODE_IND_S, MODE_IIX_S, MODE_REL_I, MODE_BIT_I,
            MODE_BTJ_I:                                           ptr_reads = 2'h1;
            default:                                              ptr_reads = 2'h0;
        endcase
    endfunction

    function automatic logic is_long(input cad_mode_e m);
        is_long = (m == MODE_DIR_L) || (m == MODE_IDX_L) || (m == MODE_IND_L) || (m == MODE_IIX_L);
    endfunction

    function automatic logic long_ok(input logic [5:0] id);
        logic [63:0] mask;
        mask    = `CAD_LONG_OK_MASK;
        long_ok = mask[id];
    endfunction

    function automatic cad_class_e insn_class(input logic [5:0] id);
        if (id >= `CAD_ID_CCFLAG)      insn_class = CLS_CCFLAG;
        else if (id >= `CAD_ID_INTR)   insn_class = CLS_INTR;
        else if (id >= `CAD_ID_COND)   insn_class = CLS_COND;
        else if (id >= `CAD_ID_UNCOND) insn_class = CLS_UNCOND;
        else if (id >= `CAD_ID_SHIFT)  insn_class = CLS_SHIFT;
        else if (id >= `CAD_ID_ARITH)  insn_class = CLS_ARITH;
        else if (id >= `CAD_ID_BITJMP) insn_class = CLS_BITJMP;
        else if (id >= `CAD_ID_BITOP)  insn_class = CLS_BITOP;
        else if (id >= `CAD_ID_LOGICAL) insn_class = CLS_LOGICAL;
        else if (id >= `CAD_ID_COMPARE) insn_class = CLS_COMPARE;
        else if (id >= `CAD_ID_INCDEC) insn_class = CLS_INCDEC;
        else if (id >= `CAD_ID_STACK)  insn_class = CLS_STACK;
        else                           insn_class = CLS_LOAD;
    endfunction
endpackage : cad_pkg

//--- cad_prefix_map.sv
// Applies a prefix byte to the base addressing mode of an opcode.
module cad_prefix_map (
    // Decoded inputs
    input  wire cad_pkg::cad_pfx_e  pfx_i,
    input  wire cad_pkg::cad_mode_e base_i,
    // Resulting mode
    output cad_pkg::cad_mode_e      mode_o,
    output logic                    use_y_o,
    output logic                    bad_o
);
    import cad_pkg::*;

    always_comb begin
        mode_o  = base_i;
        use_y_o = 1'b0;
        bad_o   = 1'b0;
        unique case (pfx_i)
            PFX_NONE: begin
            end
            PFX_Y_SUBST: begin
                use_y_o = 1'b1; // RULE_20
                bad_o   = !(base_i inside {MODE_IMM, MODE_DIR_S, MODE_DIR_L, MODE_IDX_0,
                                           MODE_IDX_S, MODE_IDX_L, MODE_INH});
            end
            PFX_INDIRECT: begin
                unique case (base_i)
                    MODE_DIR_S: mode_o = MODE_IND_S; // RULE_21
                    MODE_DIR_L: mode_o = MODE_IND_L;
                    MODE_BIT_D: mode_o = MODE_BIT_I;
                    MODE_BTJ_D: mode_o = MODE_BTJ_I;
                    MODE_REL_D: mode_o = MODE_REL_I;
                    MODE_IDX_S: mode_o = MODE_IIX_S;
                    MODE_IDX_L: mode_o = MODE_IIX_L;
                    default:    bad_o  = 1'b1;
                endcase
            end
            PFX_Y_INDIRECT: begin
                use_y_o = 1'b1; // RULE_22
                unique case (base_i)
                    MODE_IDX_S: mode_o = MODE_IIX_S;
                    MODE_IDX_L: mode_o = MODE_IIX_L;
                    default:    bad_o  = 1'b1;
                endcase
            end
        endcase
    end
endmodule // cad_prefix_map

//--- cad_ea_calc.sv
// Forms the effective address, operand and relative target of a decoded instruction.
`include "cad_defines.svh"
module cad_ea_calc (
    // Instruction
    input  wire cad_pkg::cad_mode_e mode_i,
    input  wire logic               use_y_i,
    input  wire logic [1:0][7:0]    opnd_i,
    input  wire logic [1:0][7:0]    ptr_i,
    // Core state
    input  wire logic [7:0]         idx_x_i,
    input  wire logic [7:0]         idx_y_i,
    input  wire logic [15:0]        pc_i,
    // Results
    output logic [15:0]             ea_o,
    output logic [15:0]             target_o,
    output logic [7:0]              operand_o
);
    import cad_pkg::*;

    logic [15:0] idx;
    logic [7:0]  rel_off;

    // Index registers are plain unsigned bytes, so short sums never pass 1FE.
    assign idx = {`CAD_PAGE_ZERO, (use_y_i ? idx_y_i : idx_x_i)}; // RULE_23

    always_comb begin
        operand_o = `CAD_BYTE_RST;
        rel_off   = `CAD_BYTE_RST;
        ea_o      = `CAD_WORD_RST;
        unique case (mode_i)
            MODE_INH:   ea_o = `CAD_WORD_RST; // RULE_19
            MODE_IMM:   operand_o = opnd_i[0]; // RULE_01
            MODE_DIR_S: ea_o = {`CAD_PAGE_ZERO, opnd_i[0]}; // RULE_02
            MODE_DIR_L: ea_o = {opnd_i[0], opnd_i[1]}; // RULE_03 RULE_24
            MODE_IDX_0: ea_o = idx; // RULE_05
            MODE_IDX_S: ea_o = {`CAD_PAGE_ZERO, opnd_i[0]} + idx; // RULE_04 RULE_06
            MODE_IDX_L: ea_o = {opnd_i[0], opnd_i[1]} + idx; // RULE_07
            MODE_IND_S: ea_o = {`CAD_PAGE_ZERO, ptr_i[0]}; // RULE_09
            MODE_IND_L: ea_o = {ptr_i[0], ptr_i[1]}; // RULE_10
            MODE_IIX_S: ea_o = {`CAD_PAGE_ZERO, ptr_i[0]} + idx; // RULE_11 RULE_12
            MODE_IIX_L: ea_o = {ptr_i[0], ptr_i[1]} + idx; // RULE_10 RULE_11
            MODE_REL_D: rel_off = opnd_i[0]; // RULE_16
            MODE_REL_I: rel_off = ptr_i[0]; // RULE_17
            MODE_BIT_D: ea_o = {`CAD_PAGE_ZERO, opnd_i[0]};
            MODE_BIT_I: ea_o = {`CAD_PAGE_ZERO, ptr_i[0]};
            MODE_BTJ_D: begin
                ea_o    = {`CAD_PAGE_ZERO, opnd_i[0]};
                rel_off = opnd_i[1];
            end
            MODE_BTJ_I: begin
                ea_o    = {`CAD_PAGE_ZERO, ptr_i[0]};
                rel_off = opnd_i[1];
            end
        endcase
    end

    assign target_o = pc_i + {{8{rel_off[7]}}, rel_off}; // RULE_15 RULE_23
endmodule // cad_ea_calc

//--- cad_mem_model.sv
// Data memory model that answers pointer reads after a chosen delay.
module cad_mem_model (
    // Read port
    input  wire logic        clk_i,
    input  wire logic        req_i,
    input  wire logic [15:0] addr_i,
    input  wire logic [3:0]  lat_i,
    output logic             ack_o,
    output logic [7:0]       rdata_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] wait_ff = 4'h0;
    initial begin
        ack_o = 1'b0;
        rdata_o = 8'h00;
    end
    // Outside an ack the data toggles, so a stale read never looks right.
    always @(posedge clk_i) begin
        ack_o <= 1'b0;
        rdata_o <= ~rdata_o;
        if (req_i && !ack_o) begin
            if (wait_ff >= lat_i) begin
                ack_o <= 1'b1;
                rdata_o <= addr_i[7:0] + 8'h11;
                wait_ff <= 4'h0;
            end else begin
                wait_ff <= wait_ff + 4'h1;
            end
        end
    end
endmodule // cad_mem_model

//--- tb_cpu_addressing_mode_decoder.sv
// Self-checking testbench of the addressing mode decoder.
module tb_cpu_addressing_mode_decoder;
    timeunit 1ns;
    timeprecision 1ps;
    import cad_pkg::*;
    logic        clk = 1'b0;
    logic        nrst = 1'b0;
    logic        vld = 1'b0;
    logic [7:0]  dat = 8'h00;
    cad_predec_s pd = '0;
    logic [3:0]  lat = 4'h0;
    logic        rdy, req, ack, done;
    logic [15:0] addr;
    logic [7:0]  rd;
    cad_result_s res;
    int          err_total = 0;
    int          checks = 0;
    always #2 clk = ~clk;
    cad_decoder u_cad_decoder (.SYS_CLK_I(clk), .NRST_I(nrst), .BYTE_VALID_I(vld), .BYTE_I(dat),
        .PREDEC_I(pd), .BYTE_READY_O(rdy), .IDX_X_I(8'hff), .IDX_Y_I(8'h80), .PC_I(16'h1000),
        .MEM_REQ_O(req), .MEM_ADDR_O(addr), .MEM_ACK_I(ack), .MEM_RDATA_I(rd), .DONE_O(done),
        .RESULT_O(res));
    cad_mem_model u_cad_mem_model (.clk_i(clk), .req_i(req), .addr_i(addr), .lat_i(lat),
        .ack_o(ack), .rdata_o(rd));
    task automatic summarize();
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input logic [15:0] s, input logic [15:0] e);
        checks++;
        if (s !== e) begin
            err_total++;
            $display("wrong value at %0t: seen %h expected %h", $time, s, e);
        end
    endtask
    // Ready is registered, so its value at the falling edge is what the next rising edge sees.
    task automatic snd(input logic [7:0] b);
        int k;
        k = 0;
        vld <= 1'b1;
        dat <= b;
        @(negedge clk);
        while (rdy !== 1'b1 && k < 40) begin
            k++;
            @(negedge clk);
        end
        if (k == 40) begin
            err_total++;
            summarize();
        end
        @(posedge clk);
    endtask
    task automatic run(input logic [8:0] pf, input logic [5:0] id, input cad_mode_e m,
                       input logic [1:0] n, input logic [15:0] w);
        int k;
        pd <= {id, m};
        if (pf[8]) snd(pf[7:0]);
        snd({2'h0, id});
        if (n == 2'h2) snd(w[15:8]);
        if (n != 2'h0) snd(w[7:0]);
        vld <= 1'b0;
        k = 0;
        @(negedge clk);
        while (done !== 1'b1 && k < 40) begin
            k++;
            @(negedge clk);
        end
        if (k == 40) begin
            err_total++;
            summarize();
        end
        @(posedge clk);
    endtask
    task automatic t_dir();
        run(9'h000, 6'h00, MODE_IMM, 2'h1, 16'h0055);
        chk(res.operand, 16'h0055);
        chk(res.len, 16'h0001);
        run(9'h000, 6'h00, MODE_DIR_S, 2'h1, 16'h0080);
        chk(res.ea, 16'h0080);
        run(9'h000, 6'h00, MODE_DIR_L, 2'h2, 16'h1234);
        chk(res.ea, 16'h1234);
        chk(res.illegal, 16'h0000);
        run(9'h000, 6'h01, MODE_DIR_L, 2'h2, 16'h1234);
        chk(res.illegal, 16'h0001);
        $display("t_dir done");
    endtask
    task automatic t_idx();
        run(9'h000, 6'h00, MODE_IDX_0, 2'h0, 16'h0000);
        chk(res.ea, 16'h00ff);
        run(9'h000, 6'h00, MODE_IDX_S, 2'h1, 16'h00ff);
        chk(res.ea, 16'h01fe);
        run(9'h190, 6'h00, MODE_IDX_L, 2'h2, 16'hfff0);
        chk(res.ea, 16'h0070);
        chk(res.use_y, 16'h0001);
        $display("t_idx done");
    endtask
    task automatic t_ind();
        lat <= 4'h3;
        run(9'h192, 6'h00, MODE_DIR_S, 2'h1, 16'h0040);
        chk(res.ea, 16'h0051);
        run(9'h192, 6'h00, MODE_IDX_L, 2'h1, 16'h0040);
        chk(res.ea, 16'h5251);
        run(9'h191, 6'h00, MODE_IDX_S, 2'h1, 16'h00ee);
        chk(res.ea, 16'h017f);
        $display("t_ind done");
    endtask
    task automatic t_rel();
        run(9'h000, 6'h27, MODE_REL_D, 2'h1, 16'h0080);
        chk(res.target, 16'h0f80);
        run(9'h192, 6'h27, MODE_REL_D, 2'h1, 16'h00ee);
        chk(res.target, 16'h0fff);
        run(9'h000, 6'h3e, MODE_INH, 2'h0, 16'h0000);
        chk(res.len, 16'h0000);
        chk(res.cls, CLS_CCFLAG);
        run(9'h000, 6'h3f, MODE_INH, 2'h0, 16'h0000);
        chk(res.illegal, 16'h0001);
        run(9'h192, 6'h11, MODE_BTJ_D, 2'h2, 16'h40fe);
        chk(res.ea, 16'h0051);
        chk(res.target, 16'h0ffe);
        $display("t_rel done");
    endtask
    initial begin
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        t_dir();
        t_idx();
        t_ind();
        t_rel();
        summarize();
    end
endmodule // tb_cpu_addressing_mode_decoder
